// File: hw/csi_pkg.sv
package csi_pkg;

    localparam int          PC_W        = 23;
    localparam int          WORD_W      = 16;
    localparam int          ADDR_W      = 8;

    localparam logic [15:0] SP_RESET    = 16'h0800;
    localparam logic [15:0] FP_RESET    = 16'h0000;
    localparam logic [15:0] STAT_RESET  = 16'h0000;
    localparam logic [22:0] PC_RESET    = 23'h000000;
    localparam logic [22:0] PC_STEP     = 23'h000002;
    localparam logic [22:0] PC_STEP2    = 23'h000004;
    localparam logic [15:0] STACK_STEP  = 16'h0004;

    // register byte offsets
    localparam logic [7:0]  OFS_STACK   = 8'h00;
    localparam logic [7:0]  OFS_FRAME   = 8'h04;
    localparam logic [7:0]  OFS_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_PC      = 8'h0c;
    localparam logic [7:0]  OFS_LOOPEND = 8'h10;
    localparam logic [7:0]  OFS_ISSUE   = 8'h14;

    // status word bit positions
    localparam int BIT_CARRY   = 0;
    localparam int BIT_ZERO    = 1;
    localparam int BIT_OVF     = 2;
    localparam int BIT_NEG     = 3;
    localparam int BIT_RPT     = 4;
    localparam int BIT_IPL     = 5;
    localparam int IPL_W       = 3;
    localparam int BIT_DIGIT   = 8;
    localparam int BIT_LOOP    = 9;
    localparam int BIT_ANY_SAT = 10;
    localparam int BIT_ANY_OVF = 11;
    localparam int BIT_B_SAT   = 12;
    localparam int BIT_A_SAT   = 13;
    localparam int BIT_B_OVF   = 14;
    localparam int BIT_A_OVF   = 15;

    // cycles each instruction class occupies the execute stage
    localparam logic [1:0] CYC_ONE   = 2'h1;
    localparam logic [1:0] CYC_TWO   = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;

    typedef enum logic [2:0] {
        CLS_NORMAL, CLS_BRANCH, CLS_RETURN, CLS_SKIP2,
        CLS_DMOVE, CLS_TABLE, CLS_LONGJUMP, CLS_LOOP
    } csi_op_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } csi_apb_s;

    typedef struct packed {
        logic alu_we;
        logic carry_in_op;
        logic res_zero;
        logic res_neg;
        logic res_carry;
        logic res_ovf;
        logic res_digit;
        logic dsp_we;
        logic acc_a_ovf;
        logic acc_b_ovf;
        logic acc_a_sat;
        logic acc_b_sat;
    } csi_flag_s;

endpackage

// File: hw/csi_core.sv
`timescale 1ns/100ps
// What this block does
// RL1 - stack pointer bit 0 always reads and holds zero
// RL2 - reset loads the stack pointer with 0x0800
// RL3 - calls, exceptions and returns move the stack pointer; software may too
// RL4 - link and unlink use the frame pointer; software may access it
// RL5 - sixteen-bit status word with ALU, priority, repeat, DSP and loop flags
// RL6 - exception entry stacks status low byte joined with PC top seven bits
// RL7 - loop active flag can be read and cleared, never set by software
// RL8 - repeat active flag is read only, set on repeat entry
// RL9 - overflow flags are read only, set by overflow detection only
// RL10 - saturation flags are sticky until software clears them
// RL11 - clearing the combined saturation flag clears both accumulator ones
// RL12 - status write is dropped when the same cycle updates flags
// RL13 - carry-input instructions may clear zero but never set it
// RL14 - other instructions set or clear zero from the result
// RL15 - 23-bit program counter with bit 0 always clear
// RL16 - fetch overlaps execute; plain instructions take one cycle
// RL17 - redirect discards prefetch: two cycles; returns and long skips three
// RL18 - double-word moves take two cycles
// RL19 - table access holds the fetched instruction for one cycle
// RL20 - two-word jumps and calls take the target from word two, two cycles
// RL21 - loop end is loop start plus offset, taking two cycles
// RL22 - read/write address generator conflict inserts one stall cycle, except in classes that already take three cycles
module csi_core (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire csi_pkg::csi_apb_s     apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  op_valid,
    input  wire csi_pkg::csi_op_e      op_class,
    input  wire logic                  op_redirect,
    input  wire logic [22:0]           op_target,
    input  wire logic                  agu_conflict,
    input  wire logic                  call_push,
    input  wire logic                  ret_pop,
    input  wire logic                  exc_entry,
    input  wire logic [2:0]            exc_level,
    input  wire logic                  frame_link_op,
    input  wire logic                  frame_unlink_op,
    input  wire logic [15:0]           frame_size,
    input  wire logic                  repeat_enter,
    input  wire logic                  repeat_exit,
    input  wire logic                  loop_enter,
    input  wire logic                  loop_exit,
    input  wire csi_pkg::csi_flag_s    flags,
    output logic                       issue_ready,
    output logic                       flush_prefetch,
    output logic                       fetch_hold,
    output logic                       stall,
    output logic [22:0]                program_counter,
    output logic [22:0]                loop_end_addr,
    output logic [15:0]                exc_push_word,
    output logic [15:0]                stack_pointer,
    output logic [15:0]                frame_pointer,
    output logic [15:0]                core_status_word
);

    // bus decode
    wire logic       setup_ph = apb_req.psel & ~apb_req.penable;
    wire logic       done     = apb_req.psel & apb_req.penable & pready;
    wire logic       wr_done  = done & apb_req.pwrite;
    wire logic [7:0] addr     = apb_req.paddr;
    wire logic       hit_stk  = (addr == csi_pkg::OFS_STACK);
    wire logic       hit_frm  = (addr == csi_pkg::OFS_FRAME);
    wire logic       hit_st   = (addr == csi_pkg::OFS_STATUS);
    wire logic       hit_pc   = (addr == csi_pkg::OFS_PC);
    wire logic       hit_le   = (addr == csi_pkg::OFS_LOOPEND);
    wire logic       hit_iss  = (addr == csi_pkg::OFS_ISSUE);
    wire logic       mapped   = hit_stk | hit_frm | hit_st | hit_pc
                              | hit_le | hit_iss;
    wire logic [15:0] wdat    = apb_req.pwdata[15:0];

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h00000000;
        if (hit_stk)
            rd_mux[15:0] = stack_pointer;
        if (hit_frm)
            rd_mux[15:0] = frame_pointer;
        if (hit_st)
            rd_mux[15:0] = core_status_word;
        if (hit_pc)
            rd_mux[22:0] = program_counter;
        if (hit_le)
            rd_mux[22:0] = loop_end_addr;
        if (hit_iss)
            rd_mux[3:0] = {stall, fetch_hold, flush_prefetch, issue_ready};
    end

    // answer one cycle after setup: pready is high in the first access cycle
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            if (setup_ph)
                prdata <= apb_req.pwrite ? 32'h00000000 : rd_mux;
        end
    end

    // stack and frame pointers
    wire logic sw_stk = wr_done & hit_stk;
    wire logic sw_frm = wr_done & hit_frm;
    logic [15:0] next_stack;
    logic [15:0] next_frame;
    always_comb
    begin
        next_stack = stack_pointer;
        next_frame = frame_pointer;
        if (sw_stk)
            next_stack = wdat;
        if (sw_frm)
            next_frame = wdat;
        if (frame_link_op)                                         // RL4
        begin
            next_frame = stack_pointer;
            next_stack = stack_pointer + frame_size;
        end
        else if (frame_unlink_op)                                  // RL4
            next_stack = frame_pointer;
        else if (call_push | exc_entry)                            // RL3
            next_stack = stack_pointer + csi_pkg::STACK_STEP;
        else if (ret_pop)                                          // RL3
            next_stack = stack_pointer - csi_pkg::STACK_STEP;
        next_stack[0] = 1'b0;                                      // RL1
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            stack_pointer <= csi_pkg::SP_RESET;                    // RL2
            frame_pointer <= csi_pkg::FP_RESET;
        end
        else
        begin
            stack_pointer <= next_stack;
            frame_pointer <= next_frame;
        end
    end

    // status word; hardware sets win over software clears
    wire logic flag_upd = flags.alu_we | flags.dsp_we;
    wire logic sw_st    = wr_done & hit_st & ~flag_upd;            // RL12
    logic [15:0] next_status;
    always_comb
    begin
        next_status = core_status_word;
        if (sw_st)
        begin
            next_status[csi_pkg::BIT_CARRY] = wdat[csi_pkg::BIT_CARRY];
            next_status[csi_pkg::BIT_ZERO]  = wdat[csi_pkg::BIT_ZERO];
            next_status[csi_pkg::BIT_NEG]   = wdat[csi_pkg::BIT_NEG];
            next_status[csi_pkg::BIT_DIGIT] = wdat[csi_pkg::BIT_DIGIT];
            next_status[csi_pkg::BIT_IPL +: csi_pkg::IPL_W] =
                wdat[csi_pkg::BIT_IPL +: csi_pkg::IPL_W];
            next_status[csi_pkg::BIT_LOOP] &= wdat[csi_pkg::BIT_LOOP]; // RL7
            next_status[csi_pkg::BIT_A_SAT] &= wdat[csi_pkg::BIT_A_SAT]; // RL10
            next_status[csi_pkg::BIT_B_SAT] &= wdat[csi_pkg::BIT_B_SAT];
            next_status[csi_pkg::BIT_ANY_SAT] &= wdat[csi_pkg::BIT_ANY_SAT];
            if (!wdat[csi_pkg::BIT_ANY_SAT])                       // RL11
            begin
                next_status[csi_pkg::BIT_A_SAT] = 1'b0;
                next_status[csi_pkg::BIT_B_SAT] = 1'b0;
            end
        end
        if (flags.alu_we)
        begin
            next_status[csi_pkg::BIT_CARRY] = flags.res_carry;
            next_status[csi_pkg::BIT_NEG]   = flags.res_neg;
            next_status[csi_pkg::BIT_DIGIT] = flags.res_digit;
            next_status[csi_pkg::BIT_OVF]   = flags.res_ovf;       // RL9
            if (flags.carry_in_op)                                 // RL13
                next_status[csi_pkg::BIT_ZERO] =
                    core_status_word[csi_pkg::BIT_ZERO] & flags.res_zero;
            else                                                   // RL14
                next_status[csi_pkg::BIT_ZERO] = flags.res_zero;
        end
        if (flags.dsp_we)                                          // RL9
        begin
            next_status[csi_pkg::BIT_A_OVF]   = flags.acc_a_ovf;
            next_status[csi_pkg::BIT_B_OVF]   = flags.acc_b_ovf;
            next_status[csi_pkg::BIT_ANY_OVF] = flags.acc_a_ovf
                                              | flags.acc_b_ovf;
            if (flags.acc_a_sat)                                   // RL10
                next_status[csi_pkg::BIT_A_SAT] = 1'b1;
            if (flags.acc_b_sat)
                next_status[csi_pkg::BIT_B_SAT] = 1'b1;
            if (flags.acc_a_sat | flags.acc_b_sat)
                next_status[csi_pkg::BIT_ANY_SAT] = 1'b1;
        end
        if (repeat_enter)                                          // RL8
            next_status[csi_pkg::BIT_RPT] = 1'b1;
        else if (repeat_exit)
            next_status[csi_pkg::BIT_RPT] = 1'b0;
        if (loop_enter)                                            // RL7
            next_status[csi_pkg::BIT_LOOP] = 1'b1;
        else if (loop_exit)
            next_status[csi_pkg::BIT_LOOP] = 1'b0;
        if (exc_entry)
            next_status[csi_pkg::BIT_IPL +: csi_pkg::IPL_W] = exc_level;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            core_status_word <= csi_pkg::STAT_RESET;               // RL5
            exc_push_word    <= 16'h0000;
        end
        else
        begin
            core_status_word <= next_status;
            if (exc_entry)                                         // RL6
                exc_push_word <= {1'b0, program_counter[22:16],
                                  core_status_word[7:0]};
        end
    end

    // instruction issue: remaining busy cycles of the executing instruction
    wire logic accept  = op_valid & issue_ready;
    wire logic is_flow = (op_class == csi_pkg::CLS_BRANCH)
                       | (op_class == csi_pkg::CLS_SKIP2);
    wire logic taken   = is_flow ? op_redirect : 1'b1;
    logic [1:0] base_cyc;
    always_comb
    begin
        case (op_class)
            csi_pkg::CLS_NORMAL:   base_cyc = csi_pkg::CYC_ONE;   // RL16
            csi_pkg::CLS_BRANCH:   base_cyc = csi_pkg::CYC_TWO;   // RL17
            csi_pkg::CLS_RETURN:   base_cyc = csi_pkg::CYC_THREE; // RL17
            csi_pkg::CLS_SKIP2:    base_cyc = csi_pkg::CYC_THREE; // RL17
            csi_pkg::CLS_DMOVE:    base_cyc = csi_pkg::CYC_TWO;   // RL18
            csi_pkg::CLS_TABLE:    base_cyc = csi_pkg::CYC_TWO;   // RL19
            csi_pkg::CLS_LONGJUMP: base_cyc = csi_pkg::CYC_TWO;   // RL20
            csi_pkg::CLS_LOOP:     base_cyc = csi_pkg::CYC_TWO;   // RL21
            default:               base_cyc = csi_pkg::CYC_ONE;
        endcase
        if (!taken)
            base_cyc = csi_pkg::CYC_ONE;
    end
    // a stall only fits when the class leaves headroom in the two-bit count
    wire logic add_stall = agu_conflict & (base_cyc != csi_pkg::CYC_THREE);
    wire logic [1:0] cyc = base_cyc + {1'b0, add_stall};          // RL22
    wire logic redirect  = taken & ((op_class == csi_pkg::CLS_BRANCH)
                         | (op_class == csi_pkg::CLS_RETURN)
                         | (op_class == csi_pkg::CLS_LONGJUMP));

    logic [1:0]  busy;
    logic [1:0]  next_busy;
    logic [22:0] next_pc;
    always_comb
    begin
        next_busy = (busy != 2'h0) ? busy - 2'h1 : 2'h0;
        next_pc   = program_counter;
        if (accept)
        begin
            next_busy = cyc - csi_pkg::CYC_ONE;
            if (redirect)                                          // RL20
                next_pc = op_target;
            else if (op_class == csi_pkg::CLS_LOOP)
                next_pc = program_counter + csi_pkg::PC_STEP2;
            else if (op_class == csi_pkg::CLS_SKIP2 && taken)
                next_pc = program_counter + csi_pkg::PC_STEP2
                        + csi_pkg::PC_STEP;
            else                                                   // RL16
                next_pc = program_counter + csi_pkg::PC_STEP;
        end
        next_pc[0] = 1'b0;                                         // RL15
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            busy            <= 2'h0;
            issue_ready     <= 1'b0;
            flush_prefetch  <= 1'b0;
            fetch_hold      <= 1'b0;
            stall           <= 1'b0;
            program_counter <= csi_pkg::PC_RESET;
            loop_end_addr   <= csi_pkg::PC_RESET;
        end
        else
        begin
            busy            <= next_busy;
            issue_ready     <= (next_busy == 2'h0);
            program_counter <= next_pc;
            flush_prefetch  <= accept & (redirect                  // RL17
                             | (op_class == csi_pkg::CLS_SKIP2 && taken));
            fetch_hold      <= accept
                             & (op_class == csi_pkg::CLS_TABLE);   // RL19
            stall           <= accept & add_stall;                 // RL22
            if (accept && op_class == csi_pkg::CLS_LOOP)           // RL21
                loop_end_addr <= program_counter + csi_pkg::PC_STEP2
                               + op_target;
        end
    end

    // checks
    // reset masks all but chk_stack_reset: the registers are unknown before the first edge
    chk_stack_align: assert property (@(posedge ref_clk) // RL1
        disable iff (srst) !stack_pointer[0])
        else $error("stack pointer misaligned");
    chk_stack_reset: assert property (@(posedge ref_clk) // RL2
        $past(srst) |-> stack_pointer == csi_pkg::SP_RESET)
        else $error("stack pointer reset value wrong");
    chk_call_push: assert property (@(posedge ref_clk) disable iff (srst) // RL3
        call_push && !frame_link_op && !frame_unlink_op && !sw_stk
        |=> stack_pointer == $past(stack_pointer) + csi_pkg::STACK_STEP)
        else $error("call did not advance stack");
    chk_link_frame: assert property (@(posedge ref_clk) disable iff (srst) // RL4
        frame_link_op |=> frame_pointer == $past(stack_pointer))
        else $error("link did not copy stack pointer");
    chk_loop_noset: assert property (@(posedge ref_clk) disable iff (srst) // RL7
        !core_status_word[csi_pkg::BIT_LOOP] && !loop_enter
        |=> !core_status_word[csi_pkg::BIT_LOOP])
        else $error("loop flag set without loop entry");
    chk_rpt_hold: assert property (@(posedge ref_clk) disable iff (srst) // RL8
        core_status_word[csi_pkg::BIT_RPT] && !repeat_exit
        |=> core_status_word[csi_pkg::BIT_RPT])
        else $error("repeat flag lost");
    chk_sat_sticky: assert property (@(posedge ref_clk) disable iff (srst) // RL10
        core_status_word[csi_pkg::BIT_A_SAT] && !sw_st
        |=> core_status_word[csi_pkg::BIT_A_SAT])
        else $error("saturation flag not sticky");
    chk_zero_chain: assert property (@(posedge ref_clk) disable iff (srst) // RL13
        flags.alu_we && flags.carry_in_op
        && !core_status_word[csi_pkg::BIT_ZERO]
        |=> !core_status_word[csi_pkg::BIT_ZERO])
        else $error("carry op set zero flag");
    chk_pc_even: assert property (@(posedge ref_clk) // RL15
        disable iff (srst) !program_counter[0])
        else $error("program counter odd");
    chk_ret_three: assert property (@(posedge ref_clk) disable iff (srst) // RL17
        accept && op_class == csi_pkg::CLS_RETURN
        |=> !issue_ready [*2] ##1 issue_ready)
        else $error("return not three cycles");
    chk_plain_one: assert property (@(posedge ref_clk) disable iff (srst) // RL16
        accept && op_class == csi_pkg::CLS_NORMAL && !agu_conflict
        |=> issue_ready && program_counter ==
            $past(program_counter) + csi_pkg::PC_STEP)
        else $error("plain instruction not one cycle");
    chk_stall_adds: assert property (@(posedge ref_clk) disable iff (srst) // RL22
        accept && op_class == csi_pkg::CLS_NORMAL && agu_conflict
        |=> stall && !issue_ready ##1 issue_ready)
        else $error("conflict stall wrong");

    cov_table: cover property (@(posedge ref_clk)
        accept && op_class == csi_pkg::CLS_TABLE);
    cov_loop: cover property (@(posedge ref_clk)
        accept && op_class == csi_pkg::CLS_LOOP);
    cov_sat_clear: cover property (@(posedge ref_clk)
        sw_st && !wdat[csi_pkg::BIT_ANY_SAT]);
    cov_skip_taken: cover property (@(posedge ref_clk)
        accept && op_class == csi_pkg::CLS_SKIP2 && taken);
    cov_status_block: cover property (@(posedge ref_clk)
        wr_done && hit_st && flag_upd);

endmodule // csi_core

// File: verification/csi_fetch_model.sv
`timescale 1ns/100ps
// instruction feeder: offers one op and holds it until execute takes it
module csi_fetch_model (
    input  wire logic              ref_clk,
    input  wire logic              issue_ready,
    input  wire logic              flush_prefetch,
    input  wire logic              fetch_hold,
    input  wire logic              stall,
    output logic                   op_valid,
    output csi_pkg::csi_op_e       op_class,
    output logic                   op_redirect,
    output logic [22:0]            op_target,
    output logic                   agu_conflict
);
    initial
    begin
        op_valid     = 1'b0;
        op_class     = csi_pkg::CLS_NORMAL;
        op_redirect  = 1'b0;
        op_target    = 23'h000000;
        agu_conflict = 1'b0;
    end

    // n: cycles from the taking edge until ready returns
    // p: {flush, hold, stall} seen in the cycle after taking
    task automatic issue(input csi_pkg::csi_op_e c, input logic r,
                         input logic [22:0] t, input logic k,
                         output int n, output logic [2:0] p);
        int w;
        @(posedge ref_clk);
        op_class     <= c;
        op_redirect  <= r;
        op_target    <= t;
        agu_conflict <= k;
        op_valid     <= 1'b1;
        w = 0;
        do
        begin
            @(posedge ref_clk);
            w++;
        end while (issue_ready !== 1'b1 && w < 50);
        op_valid <= 1'b0;
        n = (issue_ready === 1'b1) ? 1 : 99;
        @(posedge ref_clk);
        p = {flush_prefetch, fetch_hold, stall};
        while (issue_ready !== 1'b1 && n < 10)
        begin
            n++;
            @(posedge ref_clk);
        end
    endtask
endmodule // csi_fetch_model

// File: verification/core_status_stack_and_issue_tb.sv
`timescale 1ns/100ps
module core_status_stack_and_issue_tb;
    logic               ref_clk, srst, pready, pslverr, e, r, k, fl;
    logic               issue_ready, flush_prefetch, fetch_hold, stall;
    logic               op_valid, op_redirect, agu_conflict;
    csi_pkg::csi_apb_s  apb_req;
    csi_pkg::csi_flag_s flags;
    csi_pkg::csi_op_e   op_class, c;
    logic [8:0]         ev;
    logic [31:0]        prdata, q;
    logic [22:0]        op_target, program_counter, loop_end_addr, t;
    logic [15:0]        exc_push_word, stack_pointer, frame_pointer;
    logic [15:0]        core_status_word, frame_size;
    logic [2:0]         exc_level, p;
    int                 n_errors, n_tests, sp, fp, st, pc, n, xn, i, le;

    csi_core DUT (.ref_clk, .srst, .apb_req, .prdata, .pready, .pslverr,
        .op_valid, .op_class, .op_redirect, .op_target, .agu_conflict,
        .call_push(ev[0]), .ret_pop(ev[1]), .exc_entry(ev[2]),
        .exc_level, .frame_link_op(ev[3]), .frame_unlink_op(ev[4]),
        .frame_size, .repeat_enter(ev[5]), .repeat_exit(ev[6]),
        .loop_enter(ev[7]), .loop_exit(ev[8]), .flags, .issue_ready,
        .flush_prefetch, .fetch_hold, .stall, .program_counter,
        .loop_end_addr, .exc_push_word, .stack_pointer, .frame_pointer,
        .core_status_word);

    csi_fetch_model u_fetch (.ref_clk, .issue_ready, .flush_prefetch,
        .fetch_hold, .stall, .op_valid, .op_class, .op_redirect,
        .op_target, .agu_conflict);

    task automatic give_verdict;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        n_tests++;
        if (g !== x)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    // the write lands on the same edge as any flag strobe given here
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [11:0] f);
        int j;
        @(posedge ref_clk);
        apb_req.psel    <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite  <= w;
        apb_req.paddr   <= a;
        apb_req.pwdata  <= d;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        flags           <= csi_pkg::csi_flag_s'(f);
        j = 0;
        do
        begin
            @(posedge ref_clk);
            j++;
        end while (pready !== 1'b1 && j < 20);
        if (pready !== 1'b1)
        begin
            n_errors++;
            $display("ERROR apb_pready expected 1 seen %b", pready);
        end
        q = prdata;
        e = pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
        flags           <= '0;
        @(negedge ref_clk);
    endtask

    task automatic pulse(input logic [8:0] m, input logic [11:0] f);
        @(posedge ref_clk);
        ev    <= m;
        flags <= csi_pkg::csi_flag_s'(f);
        @(posedge ref_clk);
        ev    <= '0;
        flags <= '0;
        @(negedge ref_clk);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        #200000;
        n_errors++;
        $display("ERROR watchdog expected done seen hang");
        give_verdict();
    end

    initial
    begin
        void'($urandom(71594));
        srst = 1'b1;
        apb_req = '0;
        flags = '0;
        ev = '0;
        frame_size = 16'h0010;
        exc_level = 3'h5;
        n_errors = 0;
        n_tests = 0;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        @(negedge ref_clk);
        chk("sp_reset", 32'h0800, {16'h0000, stack_pointer});
        apb(1'b0, csi_pkg::OFS_STACK, 32'h0, 12'h000);
        chk("sp_read", 32'h0800, q);
        apb(1'b1, csi_pkg::OFS_STACK, 32'h1235, 12'h000);
        sp = 'h1234;
        apb(1'b0, csi_pkg::OFS_STACK, 32'h0, 12'h000);
        chk("sp_align", sp, q);
        pulse(9'h001, 12'h000);
        pulse(9'h001, 12'h000);
        pulse(9'h002, 12'h000);
        sp += 4;
        chk("sp_call_ret", sp, {16'h0000, stack_pointer});
        apb(1'b1, csi_pkg::OFS_FRAME, 32'h0100, 12'h000);
        pulse(9'h008, 12'h000);
        fp = sp;
        sp += 16;
        chk("fp_link", fp, {16'h0000, frame_pointer});
        chk("sp_link", sp, {16'h0000, stack_pointer});
        pulse(9'h010, 12'h000);
        sp = fp;
        chk("sp_unlink", sp, {16'h0000, stack_pointer});
        apb(1'b1, csi_pkg::OFS_STATUS, 32'hffff, 12'h000);
        chk("sr_ro", 'h01eb, {16'h0000, core_status_word});
        pulse(9'h0a0, 12'h000);
        apb(1'b1, csi_pkg::OFS_STATUS, 32'h0, 12'h000);
        chk("sr_ra_da", 'h0010, {16'h0000, core_status_word});
        pulse(9'h000, 12'h013);
        pulse(9'h000, 12'h010);
        chk("sr_sticky", 'h3410, {16'h0000, core_status_word});
        apb(1'b1, csi_pkg::OFS_STATUS, 32'h3000, 12'h000);
        chk("sr_sab", 'h0010, {16'h0000, core_status_word});
        apb(1'b1, csi_pkg::OFS_STATUS, 32'h00e0, 12'ha00);
        chk("sr_block", 'h0012, {16'h0000, core_status_word});
        pulse(9'h000, 12'hc00);
        chk("z_clear", 'h0010, {16'h0000, core_status_word});
        pulse(9'h000, 12'he00);
        chk("z_chain", 'h0010, {16'h0000, core_status_word});
        pulse(9'h000, 12'ha00);
        st = 'h0012;
        chk("z_set", st, {16'h0000, core_status_word});
        pc = 0;
        for (i = 0; i < 32; i++)
        begin
            c = csi_pkg::csi_op_e'(i % 8);
            r = i[3];
            k = i[4];
            t = 23'($urandom & (c == csi_pkg::CLS_LOOP ? 'h7ffffe : 'h7fffff));
            u_fetch.issue(c, r, t, k, n, p);
            xn = (c == csi_pkg::CLS_RETURN || (c == csi_pkg::CLS_SKIP2 && r)) ? 3 :
                 (c == csi_pkg::CLS_NORMAL || (!r && (c == csi_pkg::CLS_BRANCH ||
                  c == csi_pkg::CLS_SKIP2))) ? 1 : 2;
            fl = c == csi_pkg::CLS_RETURN || c == csi_pkg::CLS_LONGJUMP ||
                 (r && (c == csi_pkg::CLS_BRANCH || c == csi_pkg::CLS_SKIP2));
            if (c == csi_pkg::CLS_LOOP)
            begin
                le = (pc + 4 + t) & 'h7fffff;
                chk("loop_end", le, {9'h000, loop_end_addr});
            end
            if (fl && c != csi_pkg::CLS_SKIP2)
                pc = t & 'h7ffffe;
            else
                pc = (pc + (fl ? 6 : (c == csi_pkg::CLS_LOOP ? 4 : 2))) & 'h7ffffe;
            chk("cycles", xn + (k && xn != 3), n);
            chk("pulses", {fl, c == csi_pkg::CLS_TABLE, k && xn != 3}, p);
            chk("pc", pc, {9'h000, program_counter});
        end
        apb(1'b0, csi_pkg::OFS_PC, 32'h0, 12'h000);
        chk("pc_reg", pc, q);
        apb(1'b0, csi_pkg::OFS_LOOPEND, 32'h0, 12'h000);
        chk("le_reg", le, q);
        apb(1'b0, csi_pkg::OFS_ISSUE, 32'h0, 12'h000);
        chk("issue_reg", 1, q);
        xn = (((pc >> 16) & 'h7f) << 8) | (st & 'hff);
        pulse(9'h004, 12'h000);
        sp += 4;
        st = (st & 'hff1f) | (5 << 5);
        chk("push_word", xn, {16'h0000, exc_push_word});
        chk("sp_exc", sp, {16'h0000, stack_pointer});
        pulse(9'h140, 12'h000);
        chk("sr_exit", st & 'hffef, {16'h0000, core_status_word});
        apb(1'b0, 8'h20, 32'h0, 12'h000);
        chk("unmapped_err", 1, {31'h0, e});
        chk("unmapped_data", 0, q);
        give_verdict();
    end
endmodule // core_status_stack_and_issue_tb
